//--- hw/iefc_map.svh
`ifndef IEFC_MAP_SVH
`define IEFC_MAP_SVH

// Register word byte offsets on the AHB-Lite slave.
`define IEFC_OFF_CTRL 8'h00
`define IEFC_OFF_PFLAG 8'h04
`define IEFC_OFF_PEN 8'h08
`define IEFC_OFF_CFG 8'h0C
`define IEFC_OFF_PORT 8'h10
`define IEFC_OFF_TIMER 8'h14

// Field positions in interrupt_control.
`define IEFC_GHE_BIT 7
`define IEFC_PLE_BIT 6
`define IEFC_T0E_BIT 5
`define IEFC_X0E_BIT 4
`define IEFC_PCE_BIT 3
`define IEFC_T0F_BIT 2
`define IEFC_X0F_BIT 1
`define IEFC_PCF_BIT 0

// Field positions in the configuration word.
`define IEFC_PMS_BIT 0
`define IEFC_T0H_BIT 1
`define IEFC_PCH_BIT 2
`define IEFC_T1H_BIT 3
`define IEFC_T1RUN_BIT 4

// Timer-one flag and enable sit at bit 0 of their registers.
`define IEFC_T1_BIT 0

// Reset values.
`define IEFC_CTRL_RST 8'h00
`define IEFC_CFG_RST 5'h0E
`define IEFC_T1_RST 16'h0000

// Vector addresses and widths.
`define IEFC_VEC_HIGH 16'h0008
`define IEFC_VEC_LOW 16'h0018
`define IEFC_T1_WIDTH 16
`define IEFC_SYNC_STAGES 2

`endif

//--- hw/iefc_pkg.sv
`default_nettype none

package iefc_pkg;

  // Priority level of the request currently presented to the core.
  typedef enum logic [1:0] {
    IEFC_LVL_NONE,
    IEFC_LVL_LOW,
    IEFC_LVL_HIGH
  } iefc_level_t;

  // One byte of register content.
  typedef logic [7:0] iefc_byte_t;

endpackage

`default_nettype wire

//--- hw/iefc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of asynchronous pins.
module iefc_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinSync
);

  // Refuse a zero-width instance.
  if (WIDTH < 1) begin : g_bad
    $error("iefc_pin_sync needs WIDTH of at least one.");
  end

  // Each bit gets its own pair of stages; only the second stage is read.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    logic stable_reg;
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        meta_reg <= 1'b0;
        stable_reg <= 1'b0;
      end else begin
        meta_reg <= pinAsync[i];
        stable_reg <= meta_reg;
      end
    end
    assign pinSync[i] = stable_reg;
  end

endmodule

`default_nettype wire

//--- hw/iefc_timer_one.sv
`timescale 1ns/1ps
`default_nettype none

// Up-counter that wraps from all ones to zero and flags the wrap.
module iefc_timer_one #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic [WIDTH-1:0] count,
  output logic rollover
);

  // A one-bit counter would roll every other cycle, which no user wants.
  if (WIDTH < 2) begin : g_bad
    $error("iefc_timer_one needs WIDTH of at least two.");
  end

  logic [WIDTH-1:0] count_reg; // Current count.

  // A bus load wins over counting in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= loadValue;
    end else if (run) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign count = count_reg;
  // The wrap is the increment out of all ones.
  assign rollover = run && !load && (&count_reg);

endmodule

`default_nettype wire

//--- hw/iefc_ctrl.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iefc_map.svh"

// Operation
// - Flags set on events regardless of enables.
// - Normal mode: bit 7 gates all requests.
// - Priority mode: bit 7 enables high, clears all.
// - Normal mode: bit 6 gates peripheral requests.
// - Priority mode: bit 6 enables low-priority requests.
// - Bit 5 enables timer zero; bit 2 sticky flag.
// - Bit 4 enables input zero; bit 1 sticky flag.
// - Bit 3 enables port change; bit 0 flag.
// - Mismatch keeps setting flag until port read.
// - Control bits read/write, reset to zero.
// - Timer one wraps, latches its overflow flag.
// - Timer one request needs its enable bit.
// - Vector is high or low address by priority.
module iefc_ctrl
  import iefc_pkg::*;
#(
  parameter int unsigned TIMER_WIDTH = `IEFC_T1_WIDTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timerZeroOverflow,
  input wire logic extInputZeroPin,
  input wire logic [7:0] portBPins,
  output logic irqHigh,
  output logic irqLow,
  output logic [15:0] vectorAddr
);

  // The timer must fit the 32-bit data bus and be wider than one bit.
  if (TIMER_WIDTH < 2 || TIMER_WIDTH > 32) begin : g_bad
    $error("iefc_ctrl needs TIMER_WIDTH between 2 and 32.");
  end

  // Word decode used by both the address-phase and data-phase logic.
  function automatic logic hitWord(input logic [7:0] addr, input logic [7:0] offs);
    hitWord = (addr[7:2] == offs[7:2]);
  endfunction

  iefc_byte_t ctrl_reg; // Interrupt control register.
  logic pFlag_reg; // Timer-one overflow flag.
  logic pEnable_reg; // Timer-one overflow enable.
  logic [4:0] cfg_reg; // Priority mode, priorities and timer run.
  logic [7:0] portLatch_reg; // Port value captured by the last port read.
  logic extLast_reg; // Previous synchronised level of input zero.
  logic wrPend_reg; // A write data phase is due this cycle.
  logic [7:0] wrAddr_reg; // Byte address of the pending write.
  logic [31:0] hrdata_reg; // Read data for the current data phase.
  logic [15:0] vector_reg; // Vector for the most recent request.
  logic [8:0] pinsSync; // Synchronised input zero and port pins.
  logic [TIMER_WIDTH-1:0] timerCount; // Timer-one count.
  logic timerRoll; // Timer one wraps this cycle.
  logic addrPhase; // A transfer is accepted this cycle.
  logic extRise; // Rising edge seen on input zero.
  logic mismatch; // Upper port pins differ from the latched value.
  logic ctrlWrite; // Data-phase write to interrupt_control.
  logic timerLoad; // Data-phase write to the timer count.
  logic pFlagWrite; // Data-phase write to the timer-one flag.
  logic t0Req; // Timer zero flag and enable both set.
  logic extReq; // Input zero flag and enable both set.
  logic pcReq; // Port change flag and enable both set.
  logic t1Req; // Timer one flag and enable both set.
  logic hiAny; // Some source routed to high priority requests.
  logic loAny; // Some source routed to low priority requests.
  iefc_level_t reqLevel; // Level presented to the core.

  // Both the input-zero pin and the port pins come from outside.
  iefc_pin_sync #(
    .WIDTH(9)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pinAsync({extInputZeroPin, portBPins}),
    .pinSync(pinsSync)
  );

  // Timer one runs when software sets the run bit.
  iefc_timer_one #(
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(cfg_reg[`IEFC_T1RUN_BIT]),
    .load(timerLoad),
    .loadValue(hwdata[TIMER_WIDTH-1:0]),
    .count(timerCount),
    .rollover(timerRoll)
  );

  // The slave never stretches a transfer and never reports an error.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign addrPhase = hsel && htrans[1] && hready;
  assign ctrlWrite = wrPend_reg && hitWord(wrAddr_reg, `IEFC_OFF_CTRL);
  assign timerLoad = wrPend_reg && hitWord(wrAddr_reg, `IEFC_OFF_TIMER);
  assign pFlagWrite = wrPend_reg && hitWord(wrAddr_reg, `IEFC_OFF_PFLAG);

  // Only word transfers are expected, so the size is not decoded.
  logic unusedSize;
  assign unusedSize = ^hsize;

  // Address phase: remember writes and fetch read data one edge early.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= haddr[7:0];
    end
  end

  // Read data stand through the data phase; unmapped words read zero.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata_reg <= 32'h0000_0000;
      if (hitWord(haddr[7:0], `IEFC_OFF_CTRL)) begin
        hrdata_reg[7:0] <= ctrl_reg;
      end else if (hitWord(haddr[7:0], `IEFC_OFF_PFLAG)) begin
        hrdata_reg[0] <= pFlag_reg;
      end else if (hitWord(haddr[7:0], `IEFC_OFF_PEN)) begin
        hrdata_reg[0] <= pEnable_reg;
      end else if (hitWord(haddr[7:0], `IEFC_OFF_CFG)) begin
        hrdata_reg[4:0] <= cfg_reg;
      end else if (hitWord(haddr[7:0], `IEFC_OFF_PORT)) begin
        hrdata_reg[7:0] <= pinsSync[7:0];
      end else if (hitWord(haddr[7:0], `IEFC_OFF_TIMER)) begin
        hrdata_reg[TIMER_WIDTH-1:0] <= timerCount;
      end
    end
  end

  // A port read captures the pins, which ends any mismatch.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      portLatch_reg <= 8'h00;
    end else if (addrPhase && !hwrite && hitWord(haddr[7:0], `IEFC_OFF_PORT)) begin
      portLatch_reg <= pinsSync[7:0];
    end
  end

  // Edge detector looks only at the second synchroniser stage.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      extLast_reg <= 1'b0;
    end else begin
      extLast_reg <= pinsSync[8];
    end
  end

  assign extRise = pinsSync[8] && !extLast_reg;
  // Only the upper four pins take part in change detection.
  assign mismatch = (pinsSync[7:4] != portLatch_reg[7:4]);

  // Control register: software writes, then hardware sets win the same cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= `IEFC_CTRL_RST;
    end else begin
      if (ctrlWrite) begin
        ctrl_reg <= hwdata[7:0];
      end
      if (timerZeroOverflow) begin
        ctrl_reg[`IEFC_T0F_BIT] <= 1'b1;
      end
      if (extRise) begin
        ctrl_reg[`IEFC_X0F_BIT] <= 1'b1;
      end
      if (mismatch) begin
        ctrl_reg[`IEFC_PCF_BIT] <= 1'b1;
      end
    end
  end

  // Timer-one flag: a wrap outranks a software clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pFlag_reg <= 1'b0;
    end else if (timerRoll) begin
      pFlag_reg <= 1'b1;
    end else if (pFlagWrite) begin
      pFlag_reg <= hwdata[`IEFC_T1_BIT];
    end
  end

  // Timer-one enable.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pEnable_reg <= 1'b0;
    end else if (wrPend_reg && hitWord(wrAddr_reg, `IEFC_OFF_PEN)) begin
      pEnable_reg <= hwdata[`IEFC_T1_BIT];
    end
  end

  // Configuration: priority mode, per-source priority and timer run.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_reg <= `IEFC_CFG_RST;
    end else if (wrPend_reg && hitWord(wrAddr_reg, `IEFC_OFF_CFG)) begin
      cfg_reg <= hwdata[4:0];
    end
  end

  // Each source asks only with its own flag and enable both set.
  assign t0Req = ctrl_reg[`IEFC_T0E_BIT] && ctrl_reg[`IEFC_T0F_BIT];
  assign extReq = ctrl_reg[`IEFC_X0E_BIT] && ctrl_reg[`IEFC_X0F_BIT];
  assign pcReq = ctrl_reg[`IEFC_PCE_BIT] && ctrl_reg[`IEFC_PCF_BIT];
  assign t1Req = pEnable_reg && pFlag_reg;

  // Sort sources by level; input zero is always high priority.
  always_comb begin
    hiAny = extReq;
    loAny = 1'b0;
    if (!cfg_reg[`IEFC_PMS_BIT]) begin
      // Normal mode: the peripheral gate only touches timer one.
      hiAny = extReq || t0Req || pcReq || (ctrl_reg[`IEFC_PLE_BIT] && t1Req);
    end else begin
      hiAny = extReq || (t0Req && cfg_reg[`IEFC_T0H_BIT]) ||
              (pcReq && cfg_reg[`IEFC_PCH_BIT]) || (t1Req && cfg_reg[`IEFC_T1H_BIT]);
      loAny = (t0Req && !cfg_reg[`IEFC_T0H_BIT]) || (pcReq && !cfg_reg[`IEFC_PCH_BIT]) ||
              (t1Req && !cfg_reg[`IEFC_T1H_BIT]);
    end
  end

  // Bit 7 gates everything; bit 6 additionally gates the low level.
  assign irqHigh = ctrl_reg[`IEFC_GHE_BIT] && hiAny;
  assign irqLow = ctrl_reg[`IEFC_GHE_BIT] && ctrl_reg[`IEFC_PLE_BIT] && loAny;

  // High wins, since the core serves it first.
  always_comb begin
    if (irqHigh) begin
      reqLevel = IEFC_LVL_HIGH;
    end else if (irqLow) begin
      reqLevel = IEFC_LVL_LOW;
    end else begin
      reqLevel = IEFC_LVL_NONE;
    end
  end

  // The vector is held after the request goes, so the core may sample late.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vector_reg <= `IEFC_VEC_HIGH;
    end else begin
      unique case (reqLevel)
        IEFC_LVL_HIGH: begin
          vector_reg <= `IEFC_VEC_HIGH;
        end
        IEFC_LVL_LOW: begin
          vector_reg <= `IEFC_VEC_LOW;
        end
        IEFC_LVL_NONE: begin
          vector_reg <= vector_reg;
        end
        default: begin
          vector_reg <= vector_reg;
        end
      endcase
    end
  end

  assign vectorAddr = vector_reg;

  // All checks run on the one clock and are silenced while reset is held.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Flags are set by their events, whatever the enables say; requests obey the global and level gates.
  chk_flag_polled: assert property (timerZeroOverflow |=> ctrl_reg[`IEFC_T0F_BIT])
    else $error("Timer zero flag missed an overflow.");
  chk_global_block: assert property (!ctrl_reg[`IEFC_GHE_BIT] |-> !irqHigh && !irqLow)
    else $error("Request raised with global enable clear.");
  chk_high_level: assert property (cfg_reg[`IEFC_PMS_BIT] && ctrl_reg[`IEFC_GHE_BIT] &&
      extReq |-> irqHigh)
    else $error("High priority request not raised.");
  chk_periph_gate: assert property (!cfg_reg[`IEFC_PMS_BIT] &&
      !ctrl_reg[`IEFC_PLE_BIT] && !t0Req && !extReq && !pcReq |-> !irqHigh)
    else $error("Peripheral request passed a clear peripheral gate.");
  chk_low_gate: assert property (!ctrl_reg[`IEFC_PLE_BIT] || !cfg_reg[`IEFC_PMS_BIT]
      |-> !irqLow)
    else $error("Low request raised without low enable or priority mode.");

  // Sticky flags: only a write or a reset may drop them.
  chk_flag_sticky: assert property (ctrl_reg[`IEFC_T0F_BIT] && !ctrlWrite
      |=> ctrl_reg[`IEFC_T0F_BIT])
    else $error("Timer zero flag dropped without a write.");
  chk_ext_edge: assert property (extRise ##1 !ctrlWrite
      |-> ctrl_reg[`IEFC_X0F_BIT] [*2])
    else $error("Input zero flag not set on edge.");
  chk_ext_sticky: assert property (ctrl_reg[`IEFC_X0F_BIT] && !ctrlWrite
      |=> ctrl_reg[`IEFC_X0F_BIT])
    else $error("Input zero flag dropped without a write.");
  chk_change_hold: assert property (mismatch |=> ctrl_reg[`IEFC_PCF_BIT])
    else $error("Port change flag not set during mismatch.");
  chk_change_clear: assert property (ctrlWrite && !hwdata[`IEFC_PCF_BIT] && !mismatch
      |=> !ctrl_reg[`IEFC_PCF_BIT])
    else $error("Port change flag not cleared after the mismatch ended.");
  chk_ctrl_write: assert property (ctrlWrite |=> ctrl_reg[7:3] == $past(hwdata[7:3]))
    else $error("Control write did not store.");
  chk_timer_roll: assert property (timerRoll |=> pFlag_reg && timerCount == '0)
    else $error("Timer one wrap not latched.");
  chk_t1_sticky: assert property (pFlag_reg && !pFlagWrite |=> pFlag_reg)
    else $error("Timer one flag dropped without a write.");

  // Request routing and vector checks.
  chk_timer_mask: assert property (!cfg_reg[`IEFC_PMS_BIT] && !pEnable_reg &&
      !t0Req && !extReq && !pcReq |-> !irqHigh)
    else $error("Timer one request passed a clear enable.");
  chk_t1_request: assert property (t1Req && ctrl_reg[`IEFC_GHE_BIT] &&
      ctrl_reg[`IEFC_PLE_BIT] && !cfg_reg[`IEFC_PMS_BIT] |-> irqHigh)
    else $error("Enabled timer one request not raised.");
  chk_low_route: assert property (cfg_reg[`IEFC_PMS_BIT] && !cfg_reg[`IEFC_T0H_BIT] &&
      t0Req && ctrl_reg[`IEFC_GHE_BIT] && ctrl_reg[`IEFC_PLE_BIT] |-> irqLow)
    else $error("Low routed timer zero request not raised.");
  chk_vector_pick: assert property (irqLow && !irqHigh |=> vectorAddr == `IEFC_VEC_LOW)
    else $error("Low vector not chosen.");
  chk_vector_high: assert property (irqHigh |=> vectorAddr == `IEFC_VEC_HIGH)
    else $error("High vector not chosen.");

  // Main scenarios the bench is expected to reach.
  cov_high_req: cover property (!irqHigh ##1 irqHigh);
  cov_low_req: cover property (cfg_reg[`IEFC_PMS_BIT] && irqLow);
  cov_timer_wrap: cover property (timerRoll ##1 pFlag_reg);
  cov_set_on_clear: cover property (ctrlWrite && timerZeroOverflow);
  cov_low_vector: cover property (irqLow ##1 vectorAddr == `IEFC_VEC_LOW);

endmodule

`default_nettype wire

//--- testbench/iefc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural stand-in for the processor core that takes requests and vectors.
// It only watches; the block has no acknowledge input, so the core never
// answers back and cannot clear enables on entry the way real firmware would.
module iefc_core_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic irqHigh,
  input wire logic irqLow,
  input wire logic [15:0] vectorAddr,
  output logic [15:0] takenVector
);
  logic pending_reg; // A request was present on the previous edge.

  // The core fetches the vector once a request has stood for a full cycle,
  // because the vector register follows the request by one edge.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pending_reg <= 1'b0;
      takenVector <= 16'h0000;
    end else begin
      pending_reg <= irqHigh | irqLow;
      if (pending_reg && (irqHigh || irqLow)) begin
        takenVector <= vectorAddr;
      end
    end
  end
endmodule

`default_nettype wire

//--- testbench/interrupt_enable_flag_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "iefc_map.svh"

// Register-level bench: every test is a sequence of bus calls, input pin drives and compares.
module interrupt_enable_flag_control_tb;
  import iefc_pkg::*;
  logic sys_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic timerZeroOverflow, extInputZeroPin, irqHigh, irqLow;
  logic [7:0] portBPins;
  logic [15:0] vectorAddr, takenVector;
  int failures = 0;
  int num_checks = 0;

  assign hready = hreadyout; // The single slave drives the bus ready.

  iefc_ctrl dut_u (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timerZeroOverflow(timerZeroOverflow), .extInputZeroPin(extInputZeroPin),
    .portBPins(portBPins), .irqHigh(irqHigh), .irqLow(irqLow), .vectorAddr(vectorAddr));

  iefc_core_model core_u (.sys_clk(sys_clk), .srst(srst), .irqHigh(irqHigh),
    .irqLow(irqLow), .vectorAddr(vectorAddr), .takenVector(takenVector));

  // Free-running 250 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Prints the verdict and ends the run; the only place that finishes.
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares a bus word.
  task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Compares a request or vector output seen at the core side.
  task automatic check_pin(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single AHB-Lite word transfer; the master waits on ready, never on a count.
  task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rdata = hrdata;
    check_pin("hresp", 16'h0000, {15'h0000, hresp});
  endtask

  task automatic bus_write(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    bus_xfer(1'b1, addr, wdata, dummy);
  endtask

  task automatic read_check(input string name, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus_xfer(1'b0, addr, 32'h00000000, got);
    check_reg(name, exp, got);
  endtask

  // Lets registered effects land before outputs are sampled.
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end

  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    timerZeroOverflow = 1'b0;
    extInputZeroPin = 1'b0;
    portBPins = 8'h00;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values, then every control bit written both ways.
    read_check("ctrl_rst", `IEFC_OFF_CTRL, 32'h00000000);
    read_check("pflag_rst", `IEFC_OFF_PFLAG, 32'h00000000);
    read_check("pen_rst", `IEFC_OFF_PEN, 32'h00000000);
    read_check("cfg_rst", `IEFC_OFF_CFG, 32'h0000000E);
    bus_write(8'h18, 32'h000000FF);
    read_check("unmapped", 8'h18, 32'h00000000);
    bus_write(`IEFC_OFF_CTRL, 32'h000000AA);
    read_check("ctrl_aa", `IEFC_OFF_CTRL, 32'h000000AA);
    bus_write(`IEFC_OFF_CTRL, 32'h00000055);
    read_check("ctrl_55", `IEFC_OFF_CTRL, 32'h00000055);
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    // Timer-zero flag sets with every enable off and stays set.
    @(posedge sys_clk) timerZeroOverflow <= 1'b1;
    @(posedge sys_clk) timerZeroOverflow <= 1'b0;
    pause(4);
    check_pin("t0_blocked", 16'h0000, {15'h0000, irqHigh});
    read_check("t0_flag", `IEFC_OFF_CTRL, 32'h00000004);
    bus_write(`IEFC_OFF_CTRL, 32'h000000A4);
    pause(3);
    check_pin("t0_req", 16'h0001, {15'h0000, irqHigh});
    check_pin("t0_vec", `IEFC_VEC_HIGH, takenVector);
    bus_write(`IEFC_OFF_CTRL, 32'h00000024);
    pause(1);
    check_pin("t0_gie_off", 16'h0000, {15'h0000, irqHigh});
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    // External input: a rising pin sets the flag, software clears it.
    @(posedge sys_clk) extInputZeroPin <= 1'b1;
    pause(6);
    read_check("x0_flag", `IEFC_OFF_CTRL, 32'h00000002);
    bus_write(`IEFC_OFF_CTRL, 32'h00000092);
    pause(1);
    check_pin("x0_req", 16'h0001, {15'h0000, irqHigh});
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    read_check("x0_clear", `IEFC_OFF_CTRL, 32'h00000000);
    // Port change: the flag cannot be cleared until the port has been read.
    @(posedge sys_clk) portBPins <= 8'h30;
    pause(5);
    read_check("pc_flag", `IEFC_OFF_CTRL, 32'h00000001);
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    read_check("pc_stuck", `IEFC_OFF_CTRL, 32'h00000001);
    read_check("port_rd", `IEFC_OFF_PORT, 32'h00000030);
    pause(1);
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    read_check("pc_clear", `IEFC_OFF_CTRL, 32'h00000000);
    @(posedge sys_clk) portBPins <= 8'h35;
    pause(5);
    read_check("pc_low_pins", `IEFC_OFF_CTRL, 32'h00000000);
    // Timer one: load, roll over from all ones, flag latched.
    bus_write(`IEFC_OFF_TIMER, 32'h00001234);
    read_check("t1_load", `IEFC_OFF_TIMER, 32'h00001234);
    bus_write(`IEFC_OFF_CFG, 32'h0000001E);
    bus_write(`IEFC_OFF_TIMER, 32'h0000FFFD);
    pause(6);
    bus_write(`IEFC_OFF_CFG, 32'h0000000E);
    read_check("t1_flag", `IEFC_OFF_PFLAG, 32'h00000001);
    // Normal mode peripheral gating.
    bus_write(`IEFC_OFF_PEN, 32'h00000001);
    bus_write(`IEFC_OFF_CTRL, 32'h00000080);
    pause(1);
    check_pin("t1_pe_off", 16'h0000, {15'h0000, irqHigh});
    bus_write(`IEFC_OFF_CTRL, 32'h000000C0);
    pause(1);
    check_pin("t1_req", 16'h0001, {15'h0000, irqHigh});
    bus_write(`IEFC_OFF_PEN, 32'h00000000);
    pause(1);
    check_pin("t1_masked", 16'h0000, {15'h0000, irqHigh});
    bus_write(`IEFC_OFF_PEN, 32'h00000001);
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    // Priority mode with timer one routed low, then high.
    bus_write(`IEFC_OFF_CFG, 32'h00000001);
    bus_write(`IEFC_OFF_CTRL, 32'h000000C0);
    pause(3);
    check_pin("lo_req", 16'h0001, {15'h0000, irqLow});
    check_pin("lo_not_hi", 16'h0000, {15'h0000, irqHigh});
    check_pin("lo_vec", `IEFC_VEC_LOW, takenVector);
    bus_write(`IEFC_OFF_CTRL, 32'h00000080);
    pause(1);
    check_pin("lo_off", 16'h0000, {15'h0000, irqLow});
    bus_write(`IEFC_OFF_CFG, 32'h00000009);
    pause(3);
    check_pin("hi_req", 16'h0001, {15'h0000, irqHigh});
    check_pin("hi_vec", `IEFC_VEC_HIGH, takenVector);
    bus_write(`IEFC_OFF_CTRL, 32'h00000000);
    pause(1);
    check_pin("hi_off", 16'h0000, {14'h0000, irqHigh, irqLow});
    bus_write(`IEFC_OFF_PFLAG, 32'h00000000);
    read_check("t1_clear", `IEFC_OFF_PFLAG, 32'h00000000);
    // Priority mode routing of timer zero, then input zero always high.
    bus_write(`IEFC_OFF_CFG, 32'h00000003);
    bus_write(`IEFC_OFF_CTRL, 32'h000000A4);
    pause(1);
    check_pin("t0_hi_route", 16'h0002, {14'h0000, irqHigh, irqLow});
    bus_write(`IEFC_OFF_CFG, 32'h00000001);
    pause(1);
    check_pin("t0_lo_gated", 16'h0000, {14'h0000, irqHigh, irqLow});
    bus_write(`IEFC_OFF_CTRL, 32'h000000E4);
    pause(1);
    check_pin("t0_lo_route", 16'h0001, {14'h0000, irqHigh, irqLow});
    bus_write(`IEFC_OFF_CTRL, 32'h00000092);
    pause(1);
    check_pin("x0_hi_prio", 16'h0002, {14'h0000, irqHigh, irqLow});
    report_and_stop();
  end
endmodule

`default_nettype wire
